// file: pmdr_pkg.sv
// Purpose: shared constants and types for the dma register block
// Assumes: 32-bit register words, 25 MHz system clock
// Notes:   offsets, field positions and reset values are named here; other files also use them as literals
package pmdr_pkg;
  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] OFS_PCI_ADDR  = 8'h40;
  localparam logic [7:0] OFS_RAM_ADDR  = 8'h44;
  localparam logic [7:0] OFS_CTRL      = 8'h48;
  localparam logic [7:0] BAR2_SPAN_MSK = 8'hff;   // 256-byte io window
  localparam logic [1:0] BE_PCI_ADDR   = 2'h0;
  localparam logic [1:0] BE_RAM_ADDR   = 2'h1;
  localparam logic [1:0] BE_CTRL       = 2'h2;

  // ***************************************************************
  // control word fields
  // ***************************************************************
  localparam int CW_ERR_LO   = 0;
  localparam int CW_DONE     = 2;
  localparam int CW_DIR      = 3;
  localparam int CW_REQ      = 4;
  localparam int CW_EN       = 5;
  localparam int CW_DIRQ_ST  = 6;
  localparam int CW_DIRQ_EN  = 7;
  localparam int CW_XIRQ_ST  = 8;
  localparam int CW_XIRQ_EN  = 9;
  localparam int CW_WIDE     = 10;
  localparam int CW_CYC_LO   = 11;
  localparam int CW_LEN_LO   = 16;
  localparam int CW_BURST_LO = 29;

  // ***************************************************************
  // encodings and reset values
  // ***************************************************************
  localparam logic [2:0]  CYC_MEM    = 3'h0;
  localparam logic [2:0]  CYC_CFG    = 3'h1;
  localparam logic [2:0]  CYC_IACK   = 3'h2;
  localparam logic [2:0]  CYC_IO     = 3'h4;
  localparam logic [1:0]  ERR_NONE   = 2'h0;
  localparam logic [1:0]  ERR_MABORT = 2'h1;
  localparam logic [1:0]  ERR_PARITY = 2'h2;
  localparam logic [1:0]  ERR_TABORT = 2'h3;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [12:0] LEN_MAX    = 13'h1000;  // 1024 dwords in bytes
  localparam logic [31:0] CW_WR_MASK = 32'heffc_3ffb; // writable bits

  typedef enum logic [1:0] {
    PMDR_IDLE  = 2'b00,
    PMDR_BURST = 2'b01,
    PMDR_GAP   = 2'b10
  } pmdr_state_t;

  // register-access request, shared by the pci and backend ports
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  sel;
    logic [31:0] wdata;
  } pmdr_req_t;

  // data-phase report from the protocol engine
  typedef struct packed {
    logic       phase;
    logic       last;
    logic [1:0] err;
  } pmdr_phase_t;
endpackage

// file: pmdr_decode.sv
// Purpose: turn pci config/io or backend accesses into one request
// Assumes: only one access source is active per cycle
// Notes:   io_map selects io space (1) or configuration space (0)
`timescale 1ns/100ps
module pmdr_decode (
  // pci side
  input  wire logic             cfg_sel_i,
  input  wire logic             io_sel_i,
  input  wire logic             pci_wr_i,
  input  wire logic             pci_rd_i,
  input  wire logic [7:0]       pci_addr_i,
  input  wire logic [31:0]      pci_wdata_i,
  // backend side
  input  wire logic             be_cs_i,
  input  wire logic             be_wr_i,
  input  wire logic             be_rd_i,
  input  wire logic [1:0]       be_addr_i,
  input  wire logic [31:0]      be_wdata_i,
  // build choice and result
  input  wire logic             io_map_i,
  output pmdr_pkg::pmdr_req_t   req_o
);
  // ***************************************************************
  // decode
  // ***************************************************************
  function automatic logic [2:0] map_ofs(input logic [7:0] a);
    case (a)
      pmdr_pkg::OFS_PCI_ADDR: map_ofs = {1'b1, pmdr_pkg::BE_PCI_ADDR};
      pmdr_pkg::OFS_RAM_ADDR: map_ofs = {1'b1, pmdr_pkg::BE_RAM_ADDR};
      pmdr_pkg::OFS_CTRL:     map_ofs = {1'b1, pmdr_pkg::BE_CTRL};
      default:                map_ofs = 3'h0;
    endcase
  endfunction

  logic       space_hit;
  logic [2:0] hit;

  assign space_hit = io_map_i ? io_sel_i : cfg_sel_i;
  assign hit = map_ofs(pci_addr_i & pmdr_pkg::BAR2_SPAN_MSK);

  // backend codes; code 11b decodes to nothing
  always_comb begin
    req_o = '0;
    if (be_cs_i) begin
      req_o.wr    = be_wr_i && (be_addr_i != 2'h3);
      req_o.rd    = be_rd_i && (be_addr_i != 2'h3);
      req_o.sel   = be_addr_i;
      req_o.wdata = be_wdata_i;
    end else if (space_hit && hit[2]) begin
      req_o.wr    = pci_wr_i;
      req_o.rd    = pci_rd_i;
      req_o.sel   = hit[1:0];
      req_o.wdata = pci_wdata_i;
    end
  end
endmodule

// file: pmdr_burst.sv
// Purpose: count data phases in the current burst and flag its end
// Assumes: phase pulses come from the protocol engine
// Notes:   zero limit means the whole transfer is one burst
`timescale 1ns/100ps
module pmdr_burst (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       restart_i,
  input  wire logic       phase_i,
  input  wire logic [2:0] limit_i,
  // status
  output logic            cut_o
);
  logic [6:0] count;
  logic [6:0] cap;

  assign cap = (limit_i == 3'h0) ? 7'h00 : 7'(7'h01 << (limit_i - 3'h1));

  // phase counter, cleared at every new access
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 7'h00;
    end else if (restart_i) begin
      count <= 7'h00;
    end else if (phase_i) begin
      count <= 7'(count + 7'h01);
    end
  end

  assign cut_o = (cap != 7'h00) && phase_i && (7'(count + 7'h01) >= cap);
endmodule

// file: pmdr_top.sv
// Purpose: dma control and status registers of a pci bus master
// Assumes: pci and backend accesses are synchronous to clk_sys_i
// Notes:   the protocol engine reports data phases and aborts back here
`timescale 1ns/100ps

// Contract
// - external irq status sets, write-one clears
// - external irq enable bit gates support
// - width bit selects 64-bit, zero if narrow
// - bits 15..14 read zero, ignore writes
// - cycle type encodings memory/config/iack/io
// - length low two bits always zero
// - length decrements during transfer
// - zero length means 1024 dwords
// - bit 28 reads zero
// - zero burst field means single burst
// - nonzero n limits burst 2**(n-1)
// - io mapping via third bar, 256 bytes
// - registers at 40h, 44h, 48h
// - backend two-bit address selects registers
// - request stays set until done/abort
// - done sets on finish, write zero clears
// - direction one reads pci writes ram
module pmdr_top #(
  parameter bit WIDE_BUS = 1'b0
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // pci register access
  input  wire logic              cfg_sel_i,
  input  wire logic              io_sel_i,
  input  wire logic              pci_wr_i,
  input  wire logic              pci_rd_i,
  input  wire logic [7:0]        pci_addr_i,
  input  wire logic [31:0]       pci_wdata_i,
  input  wire logic              io_map_i,
  // backend register access
  input  wire logic              be_cs_i,
  input  wire logic              be_wr_i,
  input  wire logic              be_rd_i,
  input  wire logic [1:0]        be_addr_i,
  input  wire logic [31:0]       be_wdata_i,
  // protocol engine feedback
  input  wire pmdr_pkg::pmdr_phase_t phase_i,
  input  wire logic              outside_irq_in_n,
  // register read data
  output logic [31:0]            rdata_o,
  // engine commands
  output logic                   xfer_go_o,
  output logic                   burst_end_o,
  output logic                   from_pci_o,
  output logic                   wide_o,
  output logic [2:0]             cycle_o,
  output logic [31:0]            pci_addr_o,
  output logic [31:0]            ram_addr_o,
  output logic                   pci_irq_o
);
  // ***************************************************************
  // request decode
  // ***************************************************************
  pmdr_pkg::pmdr_req_t   req;
  pmdr_pkg::pmdr_state_t state;
  logic [31:0] pci_start;
  logic [31:0] ram_start;
  logic [1:0]  err;
  logic        done;
  logic        dir;
  logic        go;
  logic        dma_en;
  logic        dirq_st;
  logic        dirq_en;
  logic        xirq_st;
  logic        xirq_en;
  logic        wide;
  logic [2:0]  cyc;
  logic [11:0] len;
  logic [2:0]  burst;
  logic        cut;
  logic        ctrl_wr;
  logic        finish;
  logic        abort;
  logic [12:0] remain;
  logic [31:0] ctrl_word;

  pmdr_decode u_decode (
    .cfg_sel_i   (cfg_sel_i),
    .io_sel_i    (io_sel_i),
    .pci_wr_i    (pci_wr_i),
    .pci_rd_i    (pci_rd_i),
    .pci_addr_i  (pci_addr_i),
    .pci_wdata_i (pci_wdata_i),
    .be_cs_i     (be_cs_i),
    .be_wr_i     (be_wr_i),
    .be_rd_i     (be_rd_i),
    .be_addr_i   (be_addr_i),
    .be_wdata_i  (be_wdata_i),
    .io_map_i    (io_map_i),
    .req_o       (req)
  );

  pmdr_burst u_burst (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .restart_i (state != pmdr_pkg::PMDR_BURST),
    .phase_i   (phase_i.phase && state == pmdr_pkg::PMDR_BURST),
    .limit_i   (burst),
    .cut_o     (cut)
  );

  assign ctrl_wr = req.wr && (req.sel == pmdr_pkg::BE_CTRL);
  assign abort   = phase_i.phase && (phase_i.err == pmdr_pkg::ERR_MABORT ||
                                     phase_i.err == pmdr_pkg::ERR_TABORT);
  assign remain  = (len == 12'h000) ? pmdr_pkg::LEN_MAX : {1'b0, len};
  assign finish  = phase_i.phase && (phase_i.last || remain == 13'h0004);

  // ***************************************************************
  // address registers
  // ***************************************************************
  // low two bits forced zero: dword boundary only
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pci_start <= pmdr_pkg::RST_WORD;
      ram_start <= pmdr_pkg::RST_WORD;
    end else if (req.wr && req.sel == pmdr_pkg::BE_PCI_ADDR) begin
      pci_start <= {req.wdata[31:2], 2'h0};
    end else if (req.wr && req.sel == pmdr_pkg::BE_RAM_ADDR) begin
      ram_start <= {req.wdata[31:2], 2'h0};
    end
  end

  // ***************************************************************
  // control word: plain fields
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir     <= 1'b0;
      dma_en  <= 1'b0;
      dirq_en <= 1'b0;
      xirq_en <= 1'b0;
      wide    <= 1'b0;
      cyc     <= pmdr_pkg::CYC_MEM;
      burst   <= 3'h0;
    end else if (ctrl_wr) begin
      dir     <= req.wdata[pmdr_pkg::CW_DIR];
      dma_en  <= req.wdata[pmdr_pkg::CW_EN];
      dirq_en <= req.wdata[pmdr_pkg::CW_DIRQ_EN];
      xirq_en <= req.wdata[pmdr_pkg::CW_XIRQ_EN];
      wide    <= WIDE_BUS & req.wdata[pmdr_pkg::CW_WIDE];
      cyc     <= req.wdata[pmdr_pkg::CW_CYC_LO +: 3];
      burst   <= req.wdata[pmdr_pkg::CW_BURST_LO +: 3];
    end
  end

  // ***************************************************************
  // transfer state
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= pmdr_pkg::PMDR_IDLE;
    end else begin
      case (state)
        pmdr_pkg::PMDR_IDLE: begin
          if (go && dma_en) begin
            state <= pmdr_pkg::PMDR_BURST;
          end
        end
        pmdr_pkg::PMDR_BURST: begin
          if (finish || abort) begin
            state <= pmdr_pkg::PMDR_IDLE;
          end else if (cut) begin
            state <= pmdr_pkg::PMDR_GAP;
          end
        end
        pmdr_pkg::PMDR_GAP: begin
          state <= pmdr_pkg::PMDR_BURST;
        end
        default: begin
          state <= pmdr_pkg::PMDR_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // request, length and error
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      go <= 1'b0;
    end else if (state == pmdr_pkg::PMDR_BURST && (finish || abort)) begin
      go <= 1'b0;
    end else if (ctrl_wr && req.wdata[pmdr_pkg::CW_REQ]) begin
      go <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      len <= 12'h000;
    end else if (state == pmdr_pkg::PMDR_BURST && phase_i.phase) begin
      len <= 12'(remain - 13'h0004);
    end else if (ctrl_wr) begin
      len <= {req.wdata[27:18], 2'h0};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err <= pmdr_pkg::ERR_NONE;
    end else if (phase_i.phase && phase_i.err != pmdr_pkg::ERR_NONE) begin
      err <= phase_i.err;
    end else if (ctrl_wr) begin
      err <= req.wdata[pmdr_pkg::CW_ERR_LO +: 2];
    end
  end

  // ***************************************************************
  // sticky status bits: hardware set beats software clear
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done    <= 1'b0;
      dirq_st <= 1'b0;
    end else if (state == pmdr_pkg::PMDR_BURST && finish) begin
      done    <= 1'b1;
      dirq_st <= 1'b1;
    end else if (ctrl_wr) begin
      if (!req.wdata[pmdr_pkg::CW_DONE]) begin
        done <= 1'b0;
      end
      if (req.wdata[pmdr_pkg::CW_DIRQ_ST]) begin
        dirq_st <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xirq_st <= 1'b0;
    end else if (!outside_irq_in_n) begin
      xirq_st <= 1'b1;
    end else if (ctrl_wr && req.wdata[pmdr_pkg::CW_XIRQ_ST]) begin
      xirq_st <= 1'b0;
    end
  end

  // ***************************************************************
  // read back and outputs
  // ***************************************************************
  // bits 15..14 zero
  assign ctrl_word = {burst, 1'b0, len, 2'h0, cyc, wide, xirq_en, xirq_st,
                      dirq_en, dirq_st, dma_en, go, dir, done, err}
                     & pmdr_pkg::CW_WR_MASK | {29'h0, done, 2'h0};

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= pmdr_pkg::RST_WORD;
    end else if (req.rd) begin
      case (req.sel)
        pmdr_pkg::BE_PCI_ADDR: rdata_o <= pci_start;
        pmdr_pkg::BE_RAM_ADDR: rdata_o <= ram_start;
        pmdr_pkg::BE_CTRL:     rdata_o <= ctrl_word;
        default:               rdata_o <= pmdr_pkg::RST_WORD;
      endcase
    end
  end

  // engine command outputs, registered
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xfer_go_o   <= 1'b0;
      burst_end_o <= 1'b0;
      from_pci_o  <= 1'b0;
      wide_o      <= 1'b0;
      cycle_o     <= pmdr_pkg::CYC_MEM;
      pci_addr_o  <= pmdr_pkg::RST_WORD;
      ram_addr_o  <= pmdr_pkg::RST_WORD;
      pci_irq_o   <= 1'b0;
    end else begin
      xfer_go_o   <= (state == pmdr_pkg::PMDR_BURST);
      burst_end_o <= cut;
      from_pci_o  <= dir;
      wide_o      <= wide;
      cycle_o     <= cyc;
      pci_addr_o  <= pci_start;
      ram_addr_o  <= ram_start;
      pci_irq_o   <= (xirq_st && xirq_en) || (dirq_st && dirq_en);
    end
  end
endmodule

// file: pmdr_engine_model.sv
// Purpose: protocol engine stand-in returning data-phase reports
// Assumes: one phase per pacing period while the block commands a burst
// Notes:   last is never raised; the block ends transfers by its own count
`timescale 1ns/100ps
module pmdr_engine_model (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // block commands and bench controls
  input  wire logic             go_i,
  input  wire logic             cut_i,
  input  wire logic             slow_i,
  input  wire logic             abort_i,
  // phase report
  output pmdr_pkg::pmdr_phase_t phase_o
);
  logic [2:0] tick;
  // ********
  // pacing
  // ********
  // honour access end
  // a cut stops phases at once, so no burst can overrun its limit
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick    <= 3'h0;
      phase_o <= '0;
    end else begin
      phase_o <= '0;
      tick    <= (go_i && !cut_i) ? tick + 3'h1 : 3'h0;
      if (go_i && !cut_i && tick == (slow_i ? 3'h5 : 3'h2)) begin
        tick          <= 3'h0;
        phase_o.phase <= 1'b1;  // an aborted phase still reports, carrying its error
        phase_o.err   <= abort_i ? pmdr_pkg::ERR_MABORT : pmdr_pkg::ERR_NONE;
      end
    end
  end
endmodule

// file: pmdr_top_asserts.sv
// Purpose: temporal checks on the dma register block ports
// Assumes: control words reach the block through the backend port
// Notes:   the burst limit is copied from backend writes only
`timescale 1ns/100ps
module pmdr_top_asserts #(
  parameter bit WIDE_BUS = 1'b0
) (
  // clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  rst_n_i,
  // backend access
  input wire logic                  be_cs_i,
  input wire logic                  be_wr_i,
  input wire logic                  be_rd_i,
  input wire logic [1:0]            be_addr_i,
  input wire logic [31:0]           be_wdata_i,
  // engine side
  input wire pmdr_pkg::pmdr_phase_t phase_i,
  input wire logic                  outside_irq_in_n,
  input wire logic [31:0]           rdata_o,
  input wire logic                  xfer_go_o,
  input wire logic                  burst_end_o,
  input wire logic                  wide_o,
  input wire logic [2:0]            cycle_o
);
  // ********
  // helpers
  // ********
  wire        rd_c = be_cs_i & be_rd_i & (be_addr_i == 2'h2);
  wire        wr_c = be_cs_i & be_wr_i & (be_addr_i == 2'h2);
  logic [2:0] lim;
  logic [7:0] cnt;
  // limit copy; the count restarts whenever the engine leaves a burst
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lim <= 3'h0;
    end else if (wr_c) begin
      lim <= be_wdata_i[31:29];
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 8'h0;
    end else begin
      cnt <= xfer_go_o ? cnt + {7'h0, phase_i.phase} : 8'h0;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ********
  // checks
  // ********
  a_rsvd_hi_zero: assert property (rd_c |=> rdata_o[15:14] == 2'h0)
    else $error("reserved bits 15:14 read nonzero");
  a_bit28_zero: assert property (rd_c |=> !rdata_o[28])
    else $error("reserved bit 28 read nonzero");
  a_len_dword: assert property (rd_c |=> rdata_o[17:16] == 2'h0)
    else $error("length low bits read nonzero");
  a_width_narrow: assert property (WIDE_BUS || !wide_o)
    else $error("wide transfers in a narrow build");
  a_ext_irq_set: assert property (!outside_irq_in_n ##1 (!outside_irq_in_n && rd_c) |=> rdata_o[8])
    else $error("external irq status not set");
  a_req_starts: assert property (wr_c && be_wdata_i[5:4] == 2'h3 |-> ##[1:3] xfer_go_o)
    else $error("request did not start a burst");
  a_abort_stops: assert property (phase_i.err == pmdr_pkg::ERR_MABORT |-> ##[1:3] !xfer_go_o)
    else $error("burst goes on after abort");
  a_one_burst: assert property (lim == 3'h0 && $past(lim) == 3'h0 |-> !burst_end_o)
    else $error("burst cut with no limit set");
  a_burst_cap: assert property (xfer_go_o && lim != 3'h0 |-> cnt <= (8'h1 << (lim - 3'h1)))
    else $error("burst longer than its limit");
  a_cycle_follow: assert property (wr_c ##1 !wr_c |=> cycle_o == $past(be_wdata_i[13:11], 2))
    else $error("cycle type output differs from write");
endmodule
bind pmdr_top pmdr_top_asserts #(.WIDE_BUS(WIDE_BUS)) u_asserts (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .be_cs_i(be_cs_i), .be_wr_i(be_wr_i),
  .be_rd_i(be_rd_i), .be_addr_i(be_addr_i), .be_wdata_i(be_wdata_i), .phase_i(phase_i),
  .outside_irq_in_n(outside_irq_in_n), .rdata_o(rdata_o), .xfer_go_o(xfer_go_o),
  .burst_end_o(burst_end_o), .wide_o(wide_o), .cycle_o(cycle_o)
);

// file: pmdr_top_tb.sv
// Purpose: self-checking bench for the dma register block
// Assumes: 32-bit build; all inputs change at falling edges
// Notes:   the engine model paces phases, prompt or slow
`timescale 1ns/100ps
module pmdr_top_tb;
  // ********
  // signals
  // ********
  logic                  clk_sys_i, rst_n_i, cfg_sel_i, io_sel_i, pci_wr_i, pci_rd_i;
  logic                  io_map_i, be_cs_i, be_wr_i, be_rd_i, outside_irq_in_n, slow, abort;
  logic [7:0]            pci_addr_i;
  logic [1:0]            be_addr_i;
  logic [31:0]           pci_wdata_i, be_wdata_i, rdata_o, w, e, pci_addr_o, ram_addr_o;
  logic [2:0]            cycle_o;
  logic                  xfer_go_o, burst_end_o, from_pci_o, wide_o, pci_irq_o;
  pmdr_pkg::pmdr_phase_t phase_i;
  int                    n_fail, tests_run, n_ph;
  logic [2:0]            cyc_tab [4] = '{pmdr_pkg::CYC_MEM, pmdr_pkg::CYC_CFG,
                                         pmdr_pkg::CYC_IACK, pmdr_pkg::CYC_IO};
  pmdr_top #(.WIDE_BUS(1'b0)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_sel_i(cfg_sel_i), .io_sel_i(io_sel_i),
    .pci_wr_i(pci_wr_i), .pci_rd_i(pci_rd_i), .pci_addr_i(pci_addr_i),
    .pci_wdata_i(pci_wdata_i), .io_map_i(io_map_i), .be_cs_i(be_cs_i), .be_wr_i(be_wr_i),
    .be_rd_i(be_rd_i), .be_addr_i(be_addr_i), .be_wdata_i(be_wdata_i), .phase_i(phase_i),
    .outside_irq_in_n(outside_irq_in_n), .rdata_o(rdata_o), .xfer_go_o(xfer_go_o),
    .burst_end_o(burst_end_o), .from_pci_o(from_pci_o), .wide_o(wide_o),
    .cycle_o(cycle_o), .pci_addr_o(pci_addr_o), .ram_addr_o(ram_addr_o),
    .pci_irq_o(pci_irq_o)
  );
  pmdr_engine_model u_eng (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(xfer_go_o), .cut_i(burst_end_o),
    .slow_i(slow), .abort_i(abort), .phase_o(phase_i)
  );
  // ********
  // clock and phase count
  // ********
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (phase_i.phase === 1'b1) n_ph++;
  end
  // ********
  // tasks
  // ********
  // one access: src 0 backend, 1 config space, 2 io space
  task automatic acc(input int src, input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys_i);
    be_cs_i     = (src == 0);
    cfg_sel_i   = (src == 1);
    io_sel_i    = (src == 2);
    be_wr_i     = wr & (src == 0);
    be_rd_i     = !wr & (src == 0);
    pci_wr_i    = wr & (src != 0);
    pci_rd_i    = !wr & (src != 0);
    be_addr_i   = a[1:0];
    pci_addr_i  = a;
    be_wdata_i  = d;
    pci_wdata_i = d;
    @(negedge clk_sys_i);
    {be_cs_i, cfg_sel_i, io_sel_i, be_wr_i, be_rd_i, pci_wr_i, pci_rd_i} = 7'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    tests_run++;
    if ((got & m) !== (exp & m)) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read data stands one cycle after the taking edge
  task automatic rd(input int src, input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    acc(src, 1'b0, a, 32'h0);
    @(negedge clk_sys_i);
    chk(rdata_o, x, m);
  endtask
  task automatic dma(input logic [31:0] c, input int nd, input logic s);
    n_ph = 0;
    slow = s;
    acc(0, 1'b1, 8'h2, c);
    rd(0, 8'h2, 32'h10, 32'h10);
    chk({31'h0, from_pci_o}, {31'h0, c[3]}, 32'h1);
    for (int i = 0; i < 9000 && rdata_o[2] !== 1'b1; i++) acc(0, 1'b0, 8'h2, 32'h0);
    chk(32'(n_ph), 32'(nd), 32'hffff_ffff);
    rd(0, 8'h2, 32'h44, 32'h54);
    chk({31'h0, pci_irq_o}, 32'h1, 32'h1);
    acc(0, 1'b1, 8'h2, 32'h40);
    rd(0, 8'h2, 32'h0, 32'hffff_ffff);
    $display("test dma %h ended", c);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ********
  // watchdog: the whole sequence needs well under 20000 cycles
  // ********
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_fail++;
    $display("wrong value at %0t: run hung", $time);
    finish_test;
  end
  // ********
  // sequence
  // ********
  initial begin
    {cfg_sel_i, io_sel_i, pci_wr_i, pci_rd_i, io_map_i, be_cs_i, be_wr_i, be_rd_i} = 8'h0;
    {pci_addr_i, be_addr_i, pci_wdata_i, be_wdata_i} = 74'h0;
    {slow, abort, rst_n_i} = 3'h0;
    outside_irq_in_n = 1'b1;
    n_fail = 0;
    tests_run = 0;
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    for (int a = 0; a < 3; a++) rd(0, a[7:0], pmdr_pkg::RST_WORD, 32'hffff_ffff);
    $display("test reset ended");
    // every cycle type, with reserved and fixed bits written as ones
    foreach (cyc_tab[i]) begin
      w = {8'hf7, 8'hff, 2'h3, cyc_tab[i], 11'h68c};
      e = {8'he7, 8'hfc, 2'h0, cyc_tab[i], 11'h288};
      acc(0, 1'b1, 8'h2, w);
      rd(0, 8'h2, e, 32'hffff_ffff);
      chk({29'h0, cycle_o}, {29'h0, cyc_tab[i]}, 32'h7);
      chk({31'h0, wide_o}, 32'h0, 32'h1);
    end
    $display("test fields ended");
    // external interrupt: set while held, clear by one, gated by enable
    outside_irq_in_n = 1'b0;
    rd(0, 8'h2, e | 32'h100, 32'hffff_ffff);
    outside_irq_in_n = 1'b1;
    chk({31'h0, pci_irq_o}, 32'h1, 32'h1);
    acc(0, 1'b1, 8'h2, w | 32'h100);
    rd(0, 8'h2, e, 32'hffff_ffff);
    acc(0, 1'b1, 8'h2, w & ~32'h200);
    outside_irq_in_n = 1'b0;
    rd(0, 8'h2, (e & ~32'h200) | 32'h100, 32'hffff_ffff);
    outside_irq_in_n = 1'b1;
    chk({31'h0, pci_irq_o}, 32'h0, 32'h1);
    acc(0, 1'b1, 8'h2, 32'h100);
    $display("test external irq ended");
    // every burst limit, both directions, prompt and slow engine
    for (int n = 0; n < 8; n++) dma({n[2:0], 1'b0, 12'h100, 8'h0, 4'hb, n[1], 3'h0}, 64, n[0]);
    dma(32'h6000_00b0, 1024, 1'b0);
    dma(32'h0010_00b0, 4, 1'b1);
    // master abort in mid-transfer
    slow = 1'b0;
    acc(0, 1'b1, 8'h2, 32'h0400_00b0);
    repeat (20) @(negedge clk_sys_i);
    abort = 1'b1;
    repeat (12) @(negedge clk_sys_i);
    abort = 1'b0;
    rd(0, 8'h2, {30'h0, pmdr_pkg::ERR_MABORT}, 32'h13);
    acc(0, 1'b1, 8'h2, 32'h40);
    rd(0, 8'h2, 32'h0, 32'hffff_ffff);
    $display("test abort ended");
    // pci paths: config map, then io map with config ignored
    acc(1, 1'b1, 8'h40, 32'h0012_3454);
    rd(0, 8'h0, 32'h0012_3454, 32'hffff_ffff);
    chk(pci_addr_o, 32'h0012_3454, 32'hffff_ffff);
    acc(1, 1'b1, 8'h44, 32'h0000_1230);
    rd(1, 8'h44, 32'h0000_1230, 32'hffff_ffff);
    io_map_i = 1'b1;
    acc(2, 1'b1, 8'h44, 32'h0000_4560);
    acc(1, 1'b1, 8'h44, 32'h0000_7890);
    rd(2, 8'h44, 32'h0000_4560, 32'hffff_ffff);
    rd(0, 8'h1, 32'h0000_4560, 32'hffff_ffff);
    chk(ram_addr_o, 32'h0000_4560, 32'hffff_ffff);
    rd(0, 8'h0, 32'h0012_3454, 32'hffff_ffff);
    rd(2, 8'h4c, 32'h0012_3454, 32'hffff_ffff);
    rd(0, 8'h3, 32'h0012_3454, 32'hffff_ffff);
    $display("test pci paths ended");
    finish_test;
  end
endmodule
